// *** logic/fqpe_regs.svh ***
`ifndef FQPE_REGS_SVH
`define FQPE_REGS_SVH
// Clock rate and the amplifier ceiling on the meter's pulse rate.
`define FQPE_CLK_HZ        200000000
`define FQPE_FMAX_HZ       120000
// Least time between two counted steps, in clock cycles.
// One channel period at the ceiling is CLK/FMAX; counting every edge of both
// channels gives four steps per period.
`define FQPE_MIN_EDGE_CYC  ((`FQPE_CLK_HZ / `FQPE_FMAX_HZ) / 4)
// Width of the rate gate: the count taken over one gate scales to the pulse frequency.
// A short gate answers quickly but resolves the rate only to one count per gate.
`define FQPE_GATE_US       50
`define FQPE_GATE_CYC      ((`FQPE_CLK_HZ / 1000000) * `FQPE_GATE_US)
// Counter and volume widths.
`define FQPE_CNT_W         32
`define FQPE_VOL_W         48
// Reset values.
`define FQPE_CNT_RST       32'h0000_0000
`endif

// *** logic/fqpe_pkg.sv ***
package fqpe_pkg;
    // Edge evaluation modes for the counter.
    typedef enum logic [1:0] {
        FQPE_MODE_X1,
        FQPE_MODE_X2,
        FQPE_MODE_X4
    } fqpe_mode_t;
    // Decoded step from one sample of the channel pair.
    typedef struct packed {
        logic step;
        logic up;
        logic err;
    } fqpe_step_t;
    // Measurement results that travel together.
    typedef struct packed {
        logic [31:0] position;
        logic [31:0] rate_counts;
        logic [47:0] volume;
        logic [47:0] flow;
    } fqpe_meas_t;
endpackage : fqpe_pkg

// *** logic/fqpe_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for the two asynchronous meter channels.
module fqpe_sync
    import fqpe_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       nrst,
    // Asynchronous channel pins and their synchronised copies.
    input  wire logic [1:0] chan_async,
    output logic [1:0]      chan_sync
);
    logic [1:0] meta_reg; // First stage, read only by the second stage.

    // Both stages reset to zero; the pins are never loaded under reset.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg  <= 2'h0;
            chan_sync <= 2'h0;
        end else begin
            meta_reg  <= chan_async;
            chan_sync <= meta_reg;
        end
    end
endmodule : fqpe_sync
`default_nettype wire

// *** logic/fqpe_eval.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fqpe_regs.svh"
module fqpe_eval
    import fqpe_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Meter channel pins, asynchronous.
    input  wire logic        chan_a_pin,
    input  wire logic        chan_b_pin,
    // Configuration, held stable by the user.
    input  wire fqpe_mode_t  edge_mode,
    input  wire logic [31:0] tooth_gap_volume,
    input  wire logic [7:0]  pulse_multiplication_factor,
    input  wire logic        clear_count,
    // Results.
    output fqpe_meas_t       meas,
    output logic [47:0]      volume_per_count,
    output logic             dir_up,
    output logic             count_pulse,
    output logic             rate_valid,
    output logic             seq_error,
    output logic             overspeed
);
    logic [1:0]  chan_s;        // Synchronised channels, bit 0 is A.
    logic [1:0]  prev_reg;      // Channel pair at the previous sample.
    fqpe_step_t  step;          // Decoded step of this sample.
    logic [31:0] gate_reg;      // Cycles into the current rate gate.
    logic [31:0] win_reg;       // Counted edges within the current gate.
    logic [31:0] gap_reg;       // Cycles since the last counted edge.
    logic        seen_reg;      // An edge has been counted since reset.
    logic [31:0] position_reg;  // Signed up/down count of steps.
    logic [31:0] rate_reg;      // Steps counted in the last full gate.
    logic [47:0] volume_reg;    // Accumulated volume, 16 fractional bits.
    logic [47:0] flow_reg;      // Volume per count times counts per gate.

    // Steps per tooth: the factor times 1, 2 or 4 for X1, X2 or X4, as a divisor.
    function automatic logic [9:0] steps_per_tooth(input logic [7:0] f, input fqpe_mode_t m);
        logic [9:0] base;
        base = {2'h0, f};
        if (base == 10'h000) begin
            base = 10'h001;
        end
        unique case (m)
            FQPE_MODE_X1: steps_per_tooth = base;
            FQPE_MODE_X2: steps_per_tooth = {base[8:0], 1'b0};
            FQPE_MODE_X4: steps_per_tooth = {base[7:0], 2'h0};
            default:      steps_per_tooth = base;
        endcase
    endfunction : steps_per_tooth

    // Input synchroniser; no decode logic reads the first stage.
    fqpe_sync u_sync (
        .clk        (clk),
        .nrst       (nrst),
        .chan_async ({chan_b_pin, chan_a_pin}),
        .chan_sync  (chan_s)
    );

    // Decode the quadrature transition. Which edges count depends on the mode:
    // X1 takes rising A only, X2 rising and falling A, X4 every edge.
    always_comb begin
        logic a_chg;
        logic b_chg;
        a_chg = chan_s[0] ^ prev_reg[0];
        b_chg = chan_s[1] ^ prev_reg[1];
        step.err  = a_chg & b_chg;
        // A leading B means forward: an edge on A lands with A != B afterwards.
        step.up   = a_chg ? (chan_s[0] != chan_s[1]) : (chan_s[0] == chan_s[1]);
        step.step = 1'b0;
        if (!step.err) begin
            unique case (edge_mode)
                // Rising A counts whatever B shows, so X1 also counts backwards.
                FQPE_MODE_X1: step.step = a_chg & chan_s[0];
                FQPE_MODE_X2: step.step = a_chg;
                FQPE_MODE_X4: step.step = a_chg | b_chg;
                default:      step.step = 1'b0;
            endcase
        end
    end

    // Previous sample; it resets to zero like the synchroniser so no false edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= 2'h0;
        end else begin
            prev_reg <= chan_s;
        end
    end

    // Signed position counter, up or down per step.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            position_reg <= `FQPE_CNT_RST;
        end else if (clear_count) begin
            position_reg <= `FQPE_CNT_RST;
        end else if (step.step) begin
            position_reg <= step.up ? position_reg + 32'h1 : position_reg - 32'h1;
        end
    end

    // Direction and count strobe, one cycle after the decoded step.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dir_up      <= 1'b1;
            count_pulse <= 1'b0;
        end else begin
            count_pulse <= step.step;
            if (step.step) begin
                dir_up <= step.up;
            end
        end
    end

    // Sticky sequence error; a new error wins over the clear.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_error <= 1'b0;
        end else if (step.err) begin
            seq_error <= 1'b1;
        end else if (clear_count) begin
            seq_error <= 1'b0;
        end
    end

    // Volume per count is the tooth volume over the steps per tooth. The divide
    // is combinational but the inputs are static configuration, so it settles.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            volume_per_count <= 48'h0;
        end else begin
            volume_per_count <= {tooth_gap_volume, 16'h0} /
                                {38'h0, steps_per_tooth(pulse_multiplication_factor, edge_mode)};
        end
    end

    // Accumulated volume in the same 16-bit fractional scale, signed by direction.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            volume_reg <= 48'h0;
        end else if (clear_count) begin
            volume_reg <= 48'h0;
        end else if (count_pulse) begin
            volume_reg <= dir_up ? volume_reg + volume_per_count
                                 : volume_reg - volume_per_count;
        end
    end

    // Rate gate: counts steps over a fixed window; the count per gate scales to
    // frequency. A fixed gate trades latency for a divider-free rate.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate_reg         <= 32'h0;
            win_reg          <= 32'h0;
            rate_reg         <= 32'h0;
            rate_valid       <= 1'b0;
        end else begin
            rate_valid <= 1'b0;
            if (gate_reg == 32'(`FQPE_GATE_CYC - 1)) begin
                gate_reg         <= 32'h0;
                rate_reg         <= win_reg + {31'h0, step.step};
                win_reg          <= 32'h0;
                rate_valid       <= 1'b1;
            end else begin
                gate_reg <= gate_reg + 32'h1;
                win_reg  <= win_reg + {31'h0, step.step};
            end
        end
    end

    // Flow per gate: volume per count times counts in the gate.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flow_reg <= 48'h0;
        end else if (rate_valid) begin
            flow_reg <= 48'(volume_per_count * {16'h0, rate_reg});
        end
    end

    // Watch for steps closer than the X4 spacing at the meter's ceiling, in every mode, a sign of noise.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_reg   <= 32'h0;
            seen_reg  <= 1'b0;
            overspeed <= 1'b0;
        end else begin
            if (step.step) begin
                gap_reg  <= 32'h0;
                seen_reg <= 1'b1;
            end else if (gap_reg != 32'hffff_ffff) begin
                gap_reg <= gap_reg + 32'h1;
            end
            // A new overspeed event wins over a clear in the same cycle.
            if (step.step && seen_reg && gap_reg < 32'(`FQPE_MIN_EDGE_CYC)) begin
                overspeed <= 1'b1;
            end else if (clear_count) begin
                overspeed <= 1'b0;
            end
        end
    end

    // The result bundle is wired straight from its flip-flops, one driver per field.
    assign meas = '{
        position:    position_reg,
        rate_counts: rate_reg,
        volume:      volume_reg,
        flow:        flow_reg
    };
endmodule : fqpe_eval
`default_nettype wire

// *** tb/fqpe_meter_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural meter: one phase step per request, four steps per tooth pitch.
module fqpe_meter_model (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic nrst,
    // Step requests from the bench.
    input  wire logic step,
    input  wire logic up,
    input  wire logic jump,
    // Square-wave channel pins.
    output logic      chan_a_pin,
    output logic      chan_b_pin
);
    logic [1:0] ph_reg; // Quadrature phase 0..3.
    // A jump moves two phases at once so both pins change together.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) ph_reg <= 2'h0;
        else if (jump) ph_reg <= ph_reg + 2'h2;
        else if (step) ph_reg <= up ? ph_reg + 2'h1 : ph_reg - 2'h1;
    end
    // Gray coding keeps the channels a quarter period apart; A leads when up.
    assign chan_a_pin = ph_reg[1] ^ ph_reg[0];
    assign chan_b_pin = ph_reg[1];
endmodule : fqpe_meter_model
`default_nettype wire

// *** tb/fqpe_eval_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the evaluator.
module fqpe_eval_chk
    import fqpe_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Pins and configuration.
    input  wire logic        chan_a_pin,
    input  wire logic        chan_b_pin,
    input  wire fqpe_mode_t  edge_mode,
    input  wire logic        clear_count,
    // Results.
    input  wire fqpe_meas_t  meas,
    input  wire logic [47:0] volume_per_count,
    input  wire logic        dir_up,
    input  wire logic        count_pulse,
    input  wire logic        rate_valid,
    input  wire logic        seq_error,
    input  wire logic        overspeed
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_pulse_one_cycle: assert property (count_pulse |=> !count_pulse)
        else $error("count pulse too long");
    a_count_after_edge: assert property ((edge_mode == FQPE_MODE_X4)
        && ($changed(chan_a_pin) ^ $changed(chan_b_pin)) |-> ##[2:4] count_pulse)
        else $error("edge not counted");
    a_position_step: assert property (count_pulse |-> meas.position ==
        $past(meas.position) + (dir_up ? 32'h1 : 32'hffff_ffff)) else $error("bad step");
    a_dir_hold: assert property (!count_pulse |-> $stable(dir_up))
        else $error("direction moved without step");
    a_volume_step: assert property (count_pulse |=> meas.volume == $past(meas.volume)
        + (dir_up ? volume_per_count : -volume_per_count)) else $error("bad volume");
    a_err_sticky: assert property (seq_error && !clear_count |=> seq_error)
        else $error("error flag dropped");
    a_err_flag: assert property ($changed(chan_a_pin) && $changed(chan_b_pin)
        |-> ##[2:4] seq_error) else $error("double change not flagged");
    a_clear_zero: assert property (clear_count ##1 clear_count |->
        meas.position == 32'h0) else $error("clear ignored");
    a_x1_ignore_b: assert property ((edge_mode == FQPE_MODE_X1) && $changed(chan_b_pin)
        && !$changed(chan_a_pin) |-> ##1 !count_pulse [*4]) else $error("X1 counted B");
    a_rate_one_cycle: assert property (rate_valid |=> !rate_valid)
        else $error("gate strobe too long");
    a_flow_update: assert property (rate_valid |=> meas.flow ==
        48'($past(volume_per_count) * {16'h0, $past(meas.rate_counts)}))
        else $error("bad flow");
    c_down: cover property (count_pulse && !dir_up);
    c_err: cover property ($rose(seq_error));
    c_fast: cover property ($rose(overspeed));
    c_rate: cover property (rate_valid && meas.rate_counts != 32'h0);
endmodule : fqpe_eval_chk
bind fqpe_eval fqpe_eval_chk fqpe_eval_chk_i (.clk, .nrst, .chan_a_pin, .chan_b_pin,
    .edge_mode, .clear_count, .meas, .volume_per_count, .dir_up, .count_pulse,
    .rate_valid, .seq_error, .overspeed);
`default_nettype wire

// *** tb/test_fqpe_eval.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fqpe_regs.svh"
// Self-checking bench: meter model drives the pins, bench drives the rest.
module test_fqpe_eval;
    import fqpe_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, step = 1'b0, up = 1'b1, jump = 1'b0, clr = 1'b0;
    fqpe_mode_t  mode = FQPE_MODE_X4;
    logic [31:0] tooth = 32'h1;
    logic [7:0]  fac = 8'h1;
    wire logic   chan_a_pin, chan_b_pin, dir_up, count_pulse, rate_valid, seq_error, overspeed;
    fqpe_meas_t  meas;
    logic [47:0] vpc, evpc;
    logic [16:0] seed = 17'h1_18b0; // Fixed seed keeps runs repeatable.
    int          n_mismatch = 0, samples_checked = 0, k;
    logic [7:0]  facs [8] = '{8'h01, 8'h04, 8'h08, 8'h0a, 8'h10, 8'h20, 8'h40, 8'h80};
    always #2.5 clk = ~clk;
    fqpe_meter_model fqpe_meter_model_i (.clk, .nrst, .step, .up, .jump,
        .chan_a_pin, .chan_b_pin);
    fqpe_eval fqpe_eval_i (.clk, .nrst, .chan_a_pin, .chan_b_pin, .edge_mode(mode),
        .tooth_gap_volume(tooth), .pulse_multiplication_factor(fac), .clear_count(clr),
        .meas, .volume_per_count(vpc), .dir_up, .count_pulse, .rate_valid,
        .seq_error, .overspeed);
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    // Volume per count with 16 fractional bits.
    function automatic logic [47:0] vpc_of(input logic [31:0] t, input logic [7:0] f,
                                           input int m);
        return {t, 16'h0} / (48'(f) * 48'(m));
    endfunction : vpc_of
    task automatic chk_bit(input logic g, input logic e, input string s);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask : chk_bit
    task automatic chk_val(input logic [47:0] g, input logic [47:0] e, input string s);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask : chk_val
    // Waiting one step past the edge lets its updates land first.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Steps spaced by gap plus 2 cycles; 430 keeps them slower than the 416-cycle minimum.
    task automatic move(input logic u, input int n, input int gap);
        repeat (n) begin
            @(posedge clk) step <= 1'b1;
            up <= u;
            @(posedge clk) step <= 1'b0;
            tick(gap);
        end
    endtask : move
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // Bounded wait for the gate strobe; a missing strobe ends the run.
    task automatic wait_rate;
        int t;
        t = 0;
        while (rate_valid !== 1'b1 && t < 2 * `FQPE_GATE_CYC) begin
            tick(1);
            t++;
        end
        chk_bit(rate_valid, 1'b1, "gate strobe");
        if (rate_valid !== 1'b1) give_verdict();
    endtask : wait_rate
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        tick(2);
        chk_bit(dir_up, 1'b1, "dir reset");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            k = (i + 1) % 3;
            @(posedge clk) mode <= fqpe_mode_t'(k);
            fac <= facs[i];
            tooth <= {15'h0, seed};
            clr <= 1'b1;
            tick(4);
            @(posedge clk) clr <= 1'b0;
            evpc = vpc_of({15'h0, seed}, facs[i], 1 << k);
            move(1'b1, 8, 430);
            chk_val(vpc, evpc, "vpc");
            chk_val(48'(meas.position), 48'(2 << k), "pos up");
            chk_val(meas.volume, evpc * (2 << k), "vol up");
            move(1'b0, 8, 430);
            chk_val(48'(meas.position), 48'h0, "pos down");
            chk_bit(dir_up, 1'b0, "dir down");
            chk_bit(overspeed, 1'b0, "rate at ceiling");
            $display("test %0d done", i);
        end
        @(posedge clk) mode <= FQPE_MODE_X4;
        @(posedge clk) jump <= 1'b1;
        @(posedge clk) jump <= 1'b0;
        tick(8);
        chk_bit(seq_error, 1'b1, "double change");
        chk_val(48'(meas.position), 48'h0, "no count on error");
        move(1'b1, 2, 20);
        chk_bit(overspeed, 1'b1, "overspeed");
        @(posedge clk) clr <= 1'b1;
        tick(2);
        @(posedge clk) clr <= 1'b0;
        tick(2);
        chk_bit(seq_error, 1'b0, "error cleared");
        chk_bit(overspeed, 1'b0, "overspeed cleared");
        $display("test faults done");
        // Eight steps inside one gate must read back as eight counts of flow.
        wait_rate();
        move(1'b1, 8, 430);
        wait_rate();
        chk_val(48'(meas.rate_counts), 48'h8, "rate counts");
        tick(1);
        chk_val(meas.flow, evpc * 48'h8, "flow");
        $display("test rate done");
        give_verdict();
    end
    // Watchdog: a hang counts as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule : test_fqpe_eval
`default_nettype wire
